// >>> hdl/tbia_top.sv
/*
  Indirect access port to the trace message buffers of three receive
  trace buffer blocks. Each instance has select, address and data
  registers; writing the address register launches one byte access.
  Each instance owns one buffer memory that holds both pages of every
  tributary; the memory is not cleared by reset.
  Assumes a classic Wishbone master on i_ref_clk, word addressed,
  that polls the busy flag before it uses a result or starts another
  access. Only byte lane 0 carries register data.
  Reset is synchronous and active high.
*/
`timescale 1ns/1ps
`default_nettype none
module tbia_top
  import tbia_pkg::*;
#(
  parameter int NUM_GROUPS = 7,
  parameter int NUM_UNITS = 4,
  parameter int PAGE_BYTES = 64
)(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Wishbone slave
  input wire tbia_pkg::tbia_wb_req_s i_wb_req,
  output var tbia_pkg::tbia_wb_rsp_s o_wb_rsp,
  // Busy flags, one per instance
  output logic [tbia_pkg::TBIA_NUM_INST-1:0] o_busy
);
  import tbia_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  localparam int NI = TBIA_NUM_INST;
  // The group field is three bits wide, so one group beyond the count
  // stays addressable and gets storage of its own
  localparam int GRP_SLOTS = NUM_GROUPS + 1;
  localparam int BUF_DEPTH = GRP_SLOTS * NUM_UNITS * 2 * PAGE_BYTES;
  localparam int BUF_AW = $clog2(BUF_DEPTH);
  localparam logic [11:0] INST_STRIDE = TBIA_IDX_SEL_1 - TBIA_IDX_SEL_0;
  localparam logic [1:0] KIND_SEL = 2'h0;
  localparam logic [1:0] KIND_ADR = 2'h1;
  localparam logic [1:0] KIND_DAT = 2'h2;
  localparam logic [1:0] KIND_NONE = 2'h3;

  // Returns which register of instance inst a word index hits
  function automatic logic [1:0] reg_kind(input logic [11:0] idx, input int inst);
    logic [11:0] base;
    base = 12'(TBIA_IDX_SEL_0 + 12'(inst) * INST_STRIDE);
    if (idx == base)
      reg_kind = KIND_SEL;
    else if (idx == 12'(base + (TBIA_IDX_ADDR_0 - TBIA_IDX_SEL_0)))
      reg_kind = KIND_ADR;
    else if (idx == 12'(base + (TBIA_IDX_DATA_0 - TBIA_IDX_SEL_0)))
      reg_kind = KIND_DAT;
    else
      reg_kind = KIND_NONE;
  endfunction

  // Linear buffer location: tributary, then page, then byte
  function automatic logic [BUF_AW-1:0] buf_index(
    input logic [7:0] sel,
    input logic [7:0] adr
  );
    logic [31:0] trib;
    logic [31:0] pos;
    trib = 32'(sel[TBIA_SEL_GRP_LSB +: 3]) * NUM_UNITS + 32'(sel[TBIA_SEL_UNIT_LSB +: 2]);
    pos = (trib * 2 + 32'(sel[TBIA_SEL_PAGE_BIT])) * PAGE_BYTES + 32'(adr[5:0]);
    buf_index = pos[BUF_AW-1:0];
  endfunction

  // Read value of one register; unused bits read as zero
  function automatic logic [7:0] reg_value(
    input logic [1:0] kind,
    input logic [7:0] sel,
    input logic busy,
    input logic [7:0] adr,
    input logic [7:0] dat
  );
    case (kind)
      KIND_SEL: reg_value = sel;
      KIND_ADR: reg_value = {busy, adr[TBIA_ADR_BUSY_BIT-1:0]};
      KIND_DAT: reg_value = dat;
      default: reg_value = 8'h00;
    endcase
  endfunction

  logic [11:0] word_idx;
  logic bus_req;
  logic wr_lane0;
  logic ack;
  logic next_ack;
  logic [31:0] rdat;
  logic [31:0] next_rdat;

  assign word_idx = i_wb_req.adr[13:2];
  // Ack comes one cycle after a request is first seen and lasts one
  // cycle; the ack term keeps a held request from being taken twice
  assign bus_req = i_wb_req.cyc && i_wb_req.stb && !ack;
  assign wr_lane0 = bus_req && i_wb_req.we && i_wb_req.sel[0];

  // ----------------------------------------------------------------
  // Per-instance registers and access engine
  // ----------------------------------------------------------------
  logic [7:0] sel_q [NI];
  logic [7:0] adr_q [NI];
  logic [7:0] dat_q [NI];
  logic [7:0] buf_q [NI];
  logic busy_q [NI];
  logic [7:0] next_sel [NI];
  logic [7:0] next_adr [NI];
  logic [7:0] next_dat [NI];
  logic next_busy [NI];
  tbia_state_e st_q [NI];
  tbia_state_e next_st [NI];
  logic [3:0] cnt_q [NI];
  logic [3:0] next_cnt [NI];
  logic [BUF_AW-1:0] mem_a [NI];
  logic mem_we [NI];

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++)
    begin : g_inst
      logic [7:0] mem [BUF_DEPTH];
      logic [1:0] kind;
      logic wr_sel;
      logic wr_adr;
      logic wr_dat;
      logic rd_done;

      assign kind = reg_kind(word_idx, gi);
      assign wr_sel = wr_lane0 && (kind == KIND_SEL);
      assign wr_adr = wr_lane0 && (kind == KIND_ADR);
      assign wr_dat = wr_lane0 && (kind == KIND_DAT);
      assign mem_a[gi] = buf_index(sel_q[gi], adr_q[gi]);

      // ------------------------------------------------------------
      // Select register
      // ------------------------------------------------------------
      always_comb
      begin
        next_sel[gi] = sel_q[gi];
        if (wr_sel)
          next_sel[gi] = i_wb_req.dat[7:0] & TBIA_SEL_WMASK;
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_sys_rst)
          sel_q[gi] <= TBIA_RST_SEL;
        else
          sel_q[gi] <= next_sel[gi];
      end

      // ------------------------------------------------------------
      // Data register
      // ------------------------------------------------------------
      // A finishing read wins over a bus write in the same cycle
      always_comb
      begin
        next_dat[gi] = dat_q[gi];
        if (wr_dat)
          next_dat[gi] = i_wb_req.dat[7:0];
        if (rd_done)
          next_dat[gi] = buf_q[gi];
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_sys_rst)
          dat_q[gi] <= TBIA_RST_DATA;
        else
          dat_q[gi] <= next_dat[gi];
      end

      // ------------------------------------------------------------
      // Access engine
      // ------------------------------------------------------------
      // An address write is taken only while idle; one that arrives
      // during an access is dropped so the running access keeps its target
      always_comb
      begin
        next_adr[gi] = adr_q[gi];
        next_busy[gi] = busy_q[gi];
        next_st[gi] = st_q[gi];
        next_cnt[gi] = cnt_q[gi];
        mem_we[gi] = 1'b0;
        rd_done = 1'b0;
        case (st_q[gi])
          TBIA_IDLE:
          begin
            if (wr_adr)
            begin
              next_adr[gi] = i_wb_req.dat[7:0] & TBIA_ADR_WMASK;
              next_busy[gi] = 1'b1;
              next_cnt[gi] = 4'(TBIA_ACCESS_CYC);
              next_st[gi] = TBIA_WAIT;
            end
          end
          TBIA_WAIT:
          begin
            next_busy[gi] = 1'b1;
            if (cnt_q[gi] <= 4'h1)
              next_st[gi] = TBIA_DONE;
            else
              next_cnt[gi] = cnt_q[gi] - 4'h1;
          end
          TBIA_DONE:
          begin
            // Zero in the direction bit writes, one reads
            if (adr_q[gi][TBIA_ADR_RW_BIT])
              rd_done = 1'b1;
            else
              mem_we[gi] = 1'b1;
            next_busy[gi] = 1'b0;
            next_st[gi] = TBIA_IDLE;
          end
          default:
          begin
            next_st[gi] = TBIA_IDLE;
            next_busy[gi] = 1'b0;
          end
        endcase
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_sys_rst)
        begin
          adr_q[gi] <= TBIA_RST_ADR;
          busy_q[gi] <= 1'b0;
          st_q[gi] <= TBIA_IDLE;
          cnt_q[gi] <= 4'h0;
        end
        else
        begin
          adr_q[gi] <= next_adr[gi];
          busy_q[gi] <= next_busy[gi];
          st_q[gi] <= next_st[gi];
          cnt_q[gi] <= next_cnt[gi];
        end
      end

      // ------------------------------------------------------------
      // Buffer storage
      // ------------------------------------------------------------
      // Not reset; contents survive a reset of the registers
      always_ff @(posedge i_ref_clk)
      begin
        if (mem_we[gi])
          mem[mem_a[gi]] <= dat_q[gi];
        buf_q[gi] <= mem[mem_a[gi]];
      end

      assign o_busy[gi] = busy_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ack = bus_req;
    next_rdat = 32'h0000_0000;
    for (int i = 0; i < NI; i++)
    begin
      next_rdat[7:0] = next_rdat[7:0]
        | reg_value(reg_kind(word_idx, i), sel_q[i], busy_q[i], adr_q[i], dat_q[i]);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end
    else
    begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign o_wb_rsp.ack = ack;
  assign o_wb_rsp.dat = rdat;

endmodule // tbia_top
`default_nettype wire

// >>> hdl/tbia_pkg.sv
/*
  Package for the trace buffer indirect access block: register indices,
  field positions, reset values, timing counts and carrier structs.
  Assumes a 32-bit classic Wishbone slave port with word addressing.
*/
package tbia_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Register offsets are word indices; the byte address on the bus
  // is four times the index.
  localparam logic [11:0] TBIA_IDX_SEL_0 = 12'h429;
  localparam logic [11:0] TBIA_IDX_ADDR_0 = 12'h42a;
  localparam logic [11:0] TBIA_IDX_DATA_0 = 12'h42b;
  localparam logic [11:0] TBIA_IDX_SEL_1 = 12'h469;
  localparam logic [11:0] TBIA_IDX_ADDR_1 = 12'h46a;
  localparam logic [11:0] TBIA_IDX_DATA_1 = 12'h46b;
  localparam logic [11:0] TBIA_IDX_SEL_2 = 12'h4a9;
  localparam logic [11:0] TBIA_IDX_ADDR_2 = 12'h4aa;
  localparam logic [11:0] TBIA_IDX_DATA_2 = 12'h4ab;
  localparam int TBIA_NUM_INST = 3;
  localparam int TBIA_ADDR_W = 14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TBIA_SEL_PAGE_BIT = 7;
  localparam int TBIA_SEL_GRP_LSB = 2;
  localparam int TBIA_SEL_UNIT_LSB = 0;
  localparam int TBIA_ADR_BUSY_BIT = 7;
  localparam int TBIA_ADR_RW_BIT = 6;
  localparam logic [7:0] TBIA_SEL_WMASK = 8'h9f;
  localparam logic [7:0] TBIA_ADR_WMASK = 8'h7f;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] TBIA_RST_SEL = 8'h00;
  localparam logic [7:0] TBIA_RST_ADR = 8'h00;
  localparam logic [7:0] TBIA_RST_DATA = 8'h00;
  // Buffer access takes a fixed number of cycles once launched
  localparam int TBIA_ACCESS_NS = 8;
  localparam int TBIA_CLK_PERIOD_PS = 4000;
  localparam int TBIA_ACCESS_CYC =
    (TBIA_ACCESS_NS * 1000 + TBIA_CLK_PERIOD_PS - 1) / TBIA_CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TBIA_IDLE, TBIA_WAIT, TBIA_DONE} tbia_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [TBIA_ADDR_W-1:0] adr;
    logic [31:0] dat;
  } tbia_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tbia_wb_rsp_s;

endpackage

// >>> verif/tbia_chk.sv
/*
  Assertions on the indirect access port.
  Assumes binding to tbia_top ports.
*/
`timescale 1ns/1ps
`default_nettype none
module tbia_chk
  import tbia_pkg::*;
(
  // Watched ports
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire tbia_pkg::tbia_wb_req_s i_wb_req,
  input wire tbia_pkg::tbia_wb_rsp_s o_wb_rsp,
  input wire logic [tbia_pkg::TBIA_NUM_INST-1:0] o_busy
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic take;
  assign take = i_wb_req.cyc & i_wb_req.stb & ~o_wb_rsp.ack;
  sequence s_launch(idx, b);
    take && i_wb_req.we && i_wb_req.sel[0] && i_wb_req.adr[13:2] == idx && !b;
  endsequence
  sequence s_run;
    o_busy[0] [*3] ##1 !o_busy[0];
  endsequence
  property p_ack; take |=> o_wb_rsp.ack; endproperty
  property p_ack_pulse; o_wb_rsp.ack |=> !o_wb_rsp.ack; endproperty
  property p_dat_hi; o_wb_rsp.ack |-> o_wb_rsp.dat[31:8] == 24'h0; endproperty
  property p_busy_rise; s_launch(TBIA_IDX_ADDR_0, o_busy[0]) |=> o_busy[0]; endproperty
  property p_busy_run; $rose(o_busy[0]) |-> s_run; endproperty
  property p_busy_src0;
    $rose(o_busy[0]) |-> $past(take && i_wb_req.we && i_wb_req.adr[13:2] == TBIA_IDX_ADDR_0);
  endproperty
  property p_busy_src2;
    $rose(o_busy[2]) |-> $past(take && i_wb_req.we && i_wb_req.adr[13:2] == TBIA_IDX_ADDR_2);
  endproperty
  property p_rst;
    disable iff (1'b0) i_sys_rst |=> (o_busy == '0 && !o_wb_rsp.ack);
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits not zero");
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
  a_busy_run: assert property (p_busy_run) else $error("busy length wrong");
  a_busy_src0: assert property (p_busy_src0) else $error("busy 0 without launch");
  a_busy_src2: assert property (p_busy_src2) else $error("busy 2 without launch");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // tbia_chk
`default_nettype wire

// >>> verif/tbia_tb.sv
/*
  Self-checking bench for tbia_top.
  Assumes the bench acts as the Wishbone master.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tbia_pkg::*;
  typedef struct packed {logic [1:0] n; logic [7:0] s; logic [5:0] b; logic [7:0] v;} tbia_row_s;
  localparam tbia_row_s ROWS [4] = '{'{2'd0, 8'h80, 6'h00, 8'ha5}, '{2'd1, 8'h1f, 6'h3f, 8'h5a},
    '{2'd2, 8'h0d, 6'h15, 8'hff}, '{2'd0, 8'h00, 6'h00, 8'h3c}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  tbia_wb_req_s req = '0;
  tbia_wb_rsp_s rsp;
  logic [2:0] busy;
  logic [7:0] q;
  int bad_count = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  tbia_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_wb_req(req), .o_wb_rsp(rsp), .o_busy(busy));
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [11:0] ra(input logic [1:0] n, input logic [11:0] base);
    return base + 12'h40 * n;
  endfunction
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    req <= '{1'b1, 1'b1, w, 4'hf, {idx, 2'b00}, {24'h0, d}};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rsp.ack !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      bad_count++;
      end_of_test();
    end
    q = rsp.dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic poll(input logic [1:0] n, input logic [6:0] a);
    int k;
    k = 0;
    do
    begin
      wb(1'b0, ra(n, TBIA_IDX_ADDR_0), 8'h00);
      k++;
    end
    while (q[7] !== 1'b0 && k < 20);
    chk8(q, {1'b0, a});
  endtask
  task automatic launch(input logic [1:0] n, input logic [7:0] s, input logic [6:0] a);
    wb(1'b1, ra(n, TBIA_IDX_SEL_0), s);
    wb(1'b1, ra(n, TBIA_IDX_ADDR_0), {1'b0, a});
    poll(n, a);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i])
    begin
      wb(1'b1, ra(ROWS[i].n, TBIA_IDX_DATA_0), ROWS[i].v);
      launch(ROWS[i].n, ROWS[i].s, {1'b0, ROWS[i].b});
    end
    foreach (ROWS[i])
    begin
      launch(ROWS[i].n, ROWS[i].s, {1'b1, ROWS[i].b});
      wb(1'b0, ra(ROWS[i].n, TBIA_IDX_DATA_0), 8'h00);
      chk8(q, ROWS[i].v);
    end
    // ----
    // Awkward cases
    // ----
    wb(1'b1, TBIA_IDX_DATA_0, 8'h77);
    launch(2'd0, 8'h80, 7'h01);
    wb(1'b0, TBIA_IDX_DATA_0, 8'h00);
    chk8(q, 8'h77);
    launch(2'd0, 8'h80, 7'h40);
    wb(1'b0, TBIA_IDX_DATA_0, 8'h00);
    chk8(q, 8'ha5);
    wb(1'b1, TBIA_IDX_SEL_1, 8'h1f);
    wb(1'b1, TBIA_IDX_ADDR_1, 8'h7f);
    chk8({7'h0, busy[1]}, 8'h01);
    wb(1'b1, TBIA_IDX_ADDR_1, 8'h40);
    poll(2'd1, 7'h7f);
    wb(1'b0, TBIA_IDX_DATA_1, 8'h00);
    chk8(q, 8'h5a);
    wb(1'b0, 12'h400, 8'h00);
    chk8(q, 8'h00);
    wb(1'b1, TBIA_IDX_SEL_2, 8'hff);
    wb(1'b0, TBIA_IDX_SEL_2, 8'h00);
    chk8(q, TBIA_SEL_WMASK);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 3; n++)
    begin
      wb(1'b0, ra(n[1:0], TBIA_IDX_DATA_0), 8'h00);
      chk8(q, 8'h00);
    end
    end_of_test();
  end
endmodule // tb
bind tbia_top tbia_chk chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wb_req(i_wb_req),
  .o_wb_rsp(o_wb_rsp), .o_busy(o_busy));
`default_nettype wire
